// *** adc_cmd_pkg.sv ***
package adc_cmd_pkg;
	// input byte field positions
	localparam int CONV_SEL_BIT = 7;
	localparam int CH_MSB = 6;
	localparam int CH_LSB = 3;
	localparam int SCAN_MSB = 2;
	localparam int SCAN_LSB = 1;
	localparam int TEMP_BIT = 0;
	localparam int CK_MSB = 5;
	localparam int CK_LSB = 4;
	localparam int REF_MSB = 3;
	localparam int REF_LSB = 2;
	localparam int PAIR_MSB = 1;
	localparam int PAIR_LSB = 0;
	localparam int AVG_EN_BIT = 4;
	localparam int NAVG_MSB = 3;
	localparam int NAVG_LSB = 2;
	localparam int NREP_MSB = 1;
	localparam int NREP_LSB = 0;
	localparam int RST_FIFO_BIT = 3;
	// reset values
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] SETUP_RST = 8'h20;
	// mode codes
	localparam logic [1:0] SCAN_LOW = 2'h0;
	localparam logic [1:0] SCAN_HIGH = 2'h1;
	localparam logic [1:0] SCAN_REPEAT = 2'h2;
	localparam logic [1:0] SCAN_SINGLE = 2'h3;
	localparam logic [1:0] CK_EXT = 2'h3;
	localparam logic [1:0] REF_WAKE = 2'h0;
	localparam logic [1:0] REF_ON = 2'h2;
	localparam logic [1:0] REF_XDIFF = 2'h3;
	localparam logic [1:0] PAIR_UNI = 2'h2;
	localparam logic [1:0] PAIR_BI = 2'h3;
	// word layout
	localparam int RES_W = 12;
	localparam int WORD_W = 16;
	localparam int ACC_W = 17;
	// timing
	localparam int SYS_CLK_MHZ = 100;
	localparam int T_CNV_NS = 3500;
	localparam int T_TS_NS = 30000;
	localparam int T_RP_NS = 65000;
	localparam int T_CNV_CYC = (T_CNV_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int T_TS_CYC = (T_TS_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int T_RP_CYC = (T_RP_NS * SYS_CLK_MHZ + 999) / 1000;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAKE = 3'h1,
		ST_TEMP = 3'h3,
		ST_SAMPLE = 3'h2,
		ST_PUSH = 3'h6
	} seq_state_t;
endpackage : adc_cmd_pkg

// *** adc_serial_command_decoder.sv ***
// What this block does
// - route each byte by leading bits to conversion, setup, averaging or reset register
// - conversion byte: channel in bits 6..3, scan mode bits 2..1, temperature bit 0
// - temperature request gives one temperature result placed first in the scan
// - scan mode 00 converts channels 0 up to N inclusive
// - scan mode 01 converts channels N up to the highest channel
// - scan mode 10 repeats channel N, count from averaging register repeat bits
// - scan mode 11 converts channel N exactly once
// - scans give one result per single channel or pair, plus temperature; mode 10 gives one per repeat
// - clock modes 1x start on conversion write, modes 0x on start pin low pulse
// - channels reassigned as start pin or reference input are skipped
// - pair selected by lower channel; top pair dropped if a pin is reassigned
// - setup byte: clock mode bits 5..4, reference bits 3..2, pair addressing 1..0
// - pair addressing 10 or 11 stores next byte in unipolar or bipolar register
// - pair addressing 00 or 01 writes no pair register, next byte decodes fresh
// - a pair flagged in both registers is treated as unipolar
// - unipolar results straight binary, bipolar results two's complement
// - averaging enable makes each result the mean of up to 32 samples
// - clock mode 11 never averages
// - reset byte bit set clears only the FIFO, bit clear resets all registers
// - scan time is sample time times samples times results plus temp and wake
// - input sampled on rising serial clock with select low, output on falling
// - registers power up zero, setup in clock mode 10
// - clock mode 11 disables scanning, single channel per request
// - results read as two bytes: four zeros, ten bits, two sub-bits
`timescale 1ns/100ps
`default_nettype none

module result_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	generate
		if (D < 2 || (1 << AW) != D) begin : g_bad_depth
			$error("result_fifo depth must be a power of two");
		end
	endgenerate
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic do_wr;
	logic do_rd;
	assign in_ready = (count_ff != (AW+1)'(D));
	assign out_valid = (count_ff != '0);
	assign out_data = mem[rd_ptr_ff];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (ce && do_wr) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (rst || (ce && flush)) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else if (ce) begin
			if (do_wr) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule : result_fifo

module adc_serial_command_decoder #(
	parameter int NUM_CH = 16,
	parameter int FIFO_DEPTH = 8,
	parameter int T_RP_CYC = adc_cmd_pkg::T_RP_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic conversion_start_pin_n,
	input wire logic [11:0] sample_data,
	output logic dout,
	output logic sample_strobe,
	output logic [3:0] sample_chan,
	output logic sample_temp,
	output logic sample_diff,
	output logic ref_power,
	output logic busy
);
	generate
		if (NUM_CH != 8 && NUM_CH != 12 && NUM_CH != 16) begin : g_bad_ch
			$error("NUM_CH must be 8, 12 or 16");
		end
		if (T_RP_CYC < 1 || T_RP_CYC > 65535) begin : g_bad_rp
			$error("T_RP_CYC must fit the 16-bit timer");
		end
	endgenerate
	localparam logic [3:0] TOP_CH = 4'(NUM_CH - 1);
	localparam logic [3:0] REFN_CH = 4'(NUM_CH - 2);

	// serial pins pass two flops before use
	logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, cs_s3, din_s1, din_s2, cnv_s1, cnv_s2, cnv_s3;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{cs_s1, cs_s2, cs_s3} <= 3'h7;
			{din_s1, din_s2} <= 2'h0;
			{cnv_s1, cnv_s2, cnv_s3} <= 3'h7;
		end else if (ce) begin
			{sclk_s1, sclk_s2, sclk_s3} <= {sclk, sclk_s1, sclk_s2};
			{cs_s1, cs_s2, cs_s3} <= {cs_n, cs_s1, cs_s2};
			{din_s1, din_s2} <= {din, din_s1};
			{cnv_s1, cnv_s2, cnv_s3} <= {conversion_start_pin_n, cnv_s1, cnv_s2};
		end
	end
	logic sclk_rise, sclk_fall, cs_low, cs_fall, cnv_fall;
	assign sclk_rise = sclk_s2 && !sclk_s3;
	assign sclk_fall = !sclk_s2 && sclk_s3;
	assign cs_low = !cs_s2;
	assign cs_fall = !cs_s2 && cs_s3;
	assign cnv_fall = !cnv_s2 && cnv_s3;

	logic [6:0] rx_sh_ff;
	logic [2:0] rx_cnt_ff;
	logic byte_done;
	logic [7:0] rx_byte;
	assign byte_done = sclk_rise && cs_low && (rx_cnt_ff == 3'h7);
	assign rx_byte = {rx_sh_ff, din_s2};
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rx_sh_ff <= 7'h00;
			rx_cnt_ff <= 3'h0;
		end else if (ce) begin
			if (!cs_low) begin
				rx_cnt_ff <= 3'h0;
			end else if (sclk_rise) begin
				rx_sh_ff <= {rx_sh_ff[5:0], din_s2};
				rx_cnt_ff <= rx_cnt_ff + 3'h1;
			end
		end
	end

	logic pair_pend_ff, pair_bi_ff;
	logic [7:0] conv_ff, setup_ff, avg_ff, uni_ff, bi_ff;
	logic cmd, wr_conv, wr_setup, wr_avg, wr_rst, full_rst, fifo_clr, wr_pair;
	assign cmd = byte_done && !pair_pend_ff;
	assign wr_pair = byte_done && pair_pend_ff;
	assign wr_conv = cmd && rx_byte[adc_cmd_pkg::CONV_SEL_BIT];
	assign wr_setup = cmd && (rx_byte[7:6] == 2'h1);
	assign wr_avg = cmd && (rx_byte[7:5] == 3'h1);
	assign wr_rst = cmd && (rx_byte[7:4] == 4'h1);
	assign full_rst = wr_rst && !rx_byte[adc_cmd_pkg::RST_FIFO_BIT];
	assign fifo_clr = wr_rst;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pair_pend_ff <= 1'b0;
			pair_bi_ff <= 1'b0;
		end else if (ce) begin
			if (!cs_low || wr_pair || full_rst) begin
				pair_pend_ff <= 1'b0;
			end else if (wr_setup) begin
				pair_pend_ff <= rx_byte[adc_cmd_pkg::PAIR_MSB];
				pair_bi_ff <= rx_byte[adc_cmd_pkg::PAIR_LSB];
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst || (ce && full_rst)) begin
			conv_ff <= adc_cmd_pkg::REG_RST;
			setup_ff <= adc_cmd_pkg::SETUP_RST;
			avg_ff <= adc_cmd_pkg::REG_RST;
			uni_ff <= adc_cmd_pkg::REG_RST;
			bi_ff <= adc_cmd_pkg::REG_RST;
		end else if (ce) begin
			if (wr_conv) conv_ff <= rx_byte;
			if (wr_setup) setup_ff <= rx_byte;
			if (wr_avg) avg_ff <= rx_byte;
			if (wr_pair && !pair_bi_ff) uni_ff <= rx_byte;
			if (wr_pair && pair_bi_ff) bi_ff <= rx_byte;
		end
	end
	logic [1:0] ck_mode, ref_mode;
	assign ck_mode = setup_ff[adc_cmd_pkg::CK_MSB:adc_cmd_pkg::CK_LSB];
	assign ref_mode = setup_ff[adc_cmd_pkg::REF_MSB:adc_cmd_pkg::REF_LSB];

	// pin reassignment: top channel is the start pin in modes 0x, next is ref- in ref mode 11
	function automatic logic pin_taken(input logic [3:0] ch, input logic [7:0] setup);
		pin_taken = (ch == TOP_CH && !setup[adc_cmd_pkg::CK_MSB]) ||
			(ch == REFN_CH && setup[3:2] == adc_cmd_pkg::REF_XDIFF);
	endfunction : pin_taken
	function automatic logic pair_on(input logic [3:0] ch, input logic [7:0] u, input logic [7:0] b);
		pair_on = u[3'h7 - ch[3:1]] || b[3'h7 - ch[3:1]];
	endfunction : pair_on
	function automatic logic ch_skip(input logic [3:0] ch, input logic [7:0] setup,
		input logic [7:0] u, input logic [7:0] b);
		if (5'(ch) >= 5'(NUM_CH)) begin
			ch_skip = 1'b1;
		end else if (pair_on(ch, u, b)) begin
			ch_skip = ch[0] || pin_taken(ch, setup) || pin_taken(ch | 4'h1, setup);
		end else begin
			ch_skip = pin_taken(ch, setup);
		end
	endfunction : ch_skip

	adc_cmd_pkg::seq_state_t st_ff;
	logic [3:0] cur_ch_ff, last_ch_ff;
	logic [4:0] reps_ff;
	logic temp_pend_ff, is_temp_ff, bip_ff;
	logic [15:0] timer_ff;
	logic [5:0] avg_cnt_ff, n_avg_ff;
	logic [2:0] avg_sh_ff;
	logic [adc_cmd_pkg::ACC_W-1:0] acc_ff;
	logic [adc_cmd_pkg::WORD_W-1:0] res_ff;
	logic fifo_in_ready, fifo_out_valid, tx_pop;
	logic [adc_cmd_pkg::WORD_W-1:0] fifo_out_data;

	logic [7:0] csrc;
	logic [1:0] scan_sel;
	logic start_req, skip_now, last_step;
	logic [4:0] step_nxt;
	logic [adc_cmd_pkg::ACC_W-1:0] acc_sum, avg_val;
	assign csrc = wr_conv ? rx_byte : conv_ff;
	assign scan_sel = (ck_mode == adc_cmd_pkg::CK_EXT) ? adc_cmd_pkg::SCAN_SINGLE
		: csrc[adc_cmd_pkg::SCAN_MSB:adc_cmd_pkg::SCAN_LSB];
	assign start_req = ck_mode[1] ? wr_conv : cnv_fall;
	assign skip_now = ch_skip(cur_ch_ff, setup_ff, uni_ff, bi_ff);
	assign step_nxt = 5'(cur_ch_ff) + (pair_on(cur_ch_ff, uni_ff, bi_ff) ? 5'h2 : 5'h1);
	assign last_step = (reps_ff <= 5'h1) && (step_nxt > 5'(last_ch_ff));
	assign acc_sum = acc_ff + adc_cmd_pkg::ACC_W'(sample_data);
	assign avg_val = acc_sum >> avg_sh_ff;

	always_ff @(posedge sys_clk) begin
		if (sys_rst || (ce && full_rst)) begin
			st_ff <= adc_cmd_pkg::ST_IDLE;
			cur_ch_ff <= 4'h0;
			last_ch_ff <= 4'h0;
			reps_ff <= 5'h0;
			temp_pend_ff <= 1'b0;
			is_temp_ff <= 1'b0;
			bip_ff <= 1'b0;
			timer_ff <= 16'h0000;
			avg_cnt_ff <= 6'h00;
			n_avg_ff <= 6'h01;
			avg_sh_ff <= 3'h0;
			acc_ff <= '0;
			res_ff <= '0;
		end else if (ce) begin
			case (st_ff)
				adc_cmd_pkg::ST_IDLE: begin
					if (start_req) begin
						cur_ch_ff <= (scan_sel == adc_cmd_pkg::SCAN_LOW) ? 4'h0
							: csrc[adc_cmd_pkg::CH_MSB:adc_cmd_pkg::CH_LSB];
						last_ch_ff <= (scan_sel == adc_cmd_pkg::SCAN_HIGH) ? TOP_CH
							: csrc[adc_cmd_pkg::CH_MSB:adc_cmd_pkg::CH_LSB];
						reps_ff <= (scan_sel == adc_cmd_pkg::SCAN_REPEAT) ?
							5'({avg_ff[adc_cmd_pkg::NREP_MSB:adc_cmd_pkg::NREP_LSB], 2'h0}) + 5'h4
							: 5'h1;
						if (avg_ff[adc_cmd_pkg::AVG_EN_BIT] && ck_mode != adc_cmd_pkg::CK_EXT) begin
							n_avg_ff <= 6'h04 << avg_ff[adc_cmd_pkg::NAVG_MSB:adc_cmd_pkg::NAVG_LSB];
							avg_sh_ff <= 3'h2 + 3'(avg_ff[adc_cmd_pkg::NAVG_MSB:adc_cmd_pkg::NAVG_LSB]);
						end else begin
							n_avg_ff <= 6'h01;
							avg_sh_ff <= 3'h0;
						end
						temp_pend_ff <= csrc[adc_cmd_pkg::TEMP_BIT];
						avg_cnt_ff <= 6'h00;
						acc_ff <= '0;
						if (ref_mode == adc_cmd_pkg::REF_WAKE) begin
							st_ff <= adc_cmd_pkg::ST_WAKE;
							timer_ff <= 16'(T_RP_CYC - 1);
						end else if (csrc[adc_cmd_pkg::TEMP_BIT]) begin
							st_ff <= adc_cmd_pkg::ST_TEMP;
							timer_ff <= 16'(adc_cmd_pkg::T_TS_CYC - 1);
						end else begin
							st_ff <= adc_cmd_pkg::ST_SAMPLE;
							timer_ff <= 16'(adc_cmd_pkg::T_CNV_CYC - 1);
						end
					end
				end
				adc_cmd_pkg::ST_WAKE: begin
					if (timer_ff != 16'h0000) begin
						timer_ff <= timer_ff - 16'h0001;
					end else if (temp_pend_ff) begin
						st_ff <= adc_cmd_pkg::ST_TEMP;
						timer_ff <= 16'(adc_cmd_pkg::T_TS_CYC - 1);
					end else begin
						st_ff <= adc_cmd_pkg::ST_SAMPLE;
						timer_ff <= 16'(adc_cmd_pkg::T_CNV_CYC - 1);
					end
				end
				adc_cmd_pkg::ST_TEMP: begin
					if (timer_ff != 16'h0000) begin
						timer_ff <= timer_ff - 16'h0001;
					end else begin
						res_ff <= {4'h0, sample_data};
						is_temp_ff <= 1'b1;
						st_ff <= adc_cmd_pkg::ST_PUSH;
					end
				end
				adc_cmd_pkg::ST_SAMPLE: begin
					if (skip_now) begin
						if (last_step) begin
							st_ff <= adc_cmd_pkg::ST_IDLE;
						end else begin
							cur_ch_ff <= step_nxt[3:0];
						end
					end else if (timer_ff != 16'h0000) begin
						timer_ff <= timer_ff - 16'h0001;
					end else if (avg_cnt_ff == n_avg_ff - 6'h01) begin
						// result field holds ten bits and two sub-bits; bipolar msb flipped
						res_ff <= {4'h0, avg_val[11] ^ bip_ff, avg_val[10:0]};
						is_temp_ff <= 1'b0;
						st_ff <= adc_cmd_pkg::ST_PUSH;
					end else begin
						acc_ff <= acc_sum;
						avg_cnt_ff <= avg_cnt_ff + 6'h01;
						timer_ff <= 16'(adc_cmd_pkg::T_CNV_CYC - 1);
					end
				end
				adc_cmd_pkg::ST_PUSH: begin
					if (fifo_in_ready) begin
						acc_ff <= '0;
						avg_cnt_ff <= 6'h00;
						timer_ff <= 16'(adc_cmd_pkg::T_CNV_CYC - 1);
						if (is_temp_ff) begin
							temp_pend_ff <= 1'b0;
							st_ff <= adc_cmd_pkg::ST_SAMPLE;
						end else if (last_step) begin
							st_ff <= adc_cmd_pkg::ST_IDLE;
						end else begin
							st_ff <= adc_cmd_pkg::ST_SAMPLE;
							if (reps_ff > 5'h1) begin
								reps_ff <= reps_ff - 5'h1;
							end else begin
								cur_ch_ff <= step_nxt[3:0];
							end
						end
					end
				end
				default: st_ff <= adc_cmd_pkg::ST_IDLE;
			endcase
			// unipolar flag wins over bipolar for a pair
			bip_ff <= pair_on(cur_ch_ff, 8'h00, bi_ff) && !pair_on(cur_ch_ff, uni_ff, 8'h00);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sample_strobe <= 1'b0;
			sample_chan <= 4'h0;
			sample_temp <= 1'b0;
			sample_diff <= 1'b0;
			ref_power <= 1'b0;
			busy <= 1'b0;
		end else if (ce) begin
			sample_strobe <= (st_ff == adc_cmd_pkg::ST_SAMPLE && !skip_now && timer_ff == 16'h0000)
				|| (st_ff == adc_cmd_pkg::ST_TEMP && timer_ff == 16'h0000);
			sample_chan <= cur_ch_ff;
			sample_temp <= (st_ff == adc_cmd_pkg::ST_TEMP);
			sample_diff <= pair_on(cur_ch_ff, uni_ff, bi_ff);
			ref_power <= (ref_mode == adc_cmd_pkg::REF_ON) ||
				(ref_mode == adc_cmd_pkg::REF_WAKE && st_ff != adc_cmd_pkg::ST_IDLE);
			busy <= (st_ff != adc_cmd_pkg::ST_IDLE);
		end
	end

	result_fifo #(
		.W(adc_cmd_pkg::WORD_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk(sys_clk),
		.rst(sys_rst),
		.ce(ce),
		.flush(fifo_clr),
		.in_valid(st_ff == adc_cmd_pkg::ST_PUSH),
		.in_ready(fifo_in_ready),
		.in_data(res_ff),
		.out_valid(fifo_out_valid),
		.out_ready(tx_pop),
		.out_data(fifo_out_data)
	);

	// output word stays across select high unless it is an empty filler
	logic [adc_cmd_pkg::WORD_W-1:0] tx_ff;
	logic [3:0] tx_cnt_ff;
	logic tx_real_ff, tx_load;
	assign tx_load = (cs_fall && !tx_real_ff) || (sclk_fall && cs_low && tx_cnt_ff == 4'hF);
	assign tx_pop = ce && tx_load && fifo_out_valid;
	assign dout = tx_ff[adc_cmd_pkg::WORD_W-1];
	always_ff @(posedge sys_clk) begin
		if (sys_rst || (ce && fifo_clr)) begin
			tx_ff <= '0;
			tx_cnt_ff <= 4'h0;
			tx_real_ff <= 1'b0;
		end else if (ce) begin
			if (tx_load) begin
				tx_ff <= fifo_out_valid ? fifo_out_data : '0;
				tx_real_ff <= fifo_out_valid;
				tx_cnt_ff <= 4'h0;
			end else if (sclk_fall && cs_low) begin
				tx_ff <= {tx_ff[adc_cmd_pkg::WORD_W-2:0], 1'b0};
				tx_cnt_ff <= tx_cnt_ff + 4'h1;
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_setup_pair;
		ce && wr_setup && rx_byte[1];
	endsequence
	sequence s_pair_byte;
		ce && wr_pair;
	endsequence
	a_setup_default: assert property ($past(sys_rst) |-> setup_ff == 8'h20)
		else $error("setup register not at power-up value");
	a_pair_store: assert property (s_pair_byte |=>
		(pair_bi_ff ? bi_ff : uni_ff) == $past(rx_byte))
		else $error("pair byte not stored");
	a_null_ignored: assert property (ce && cmd && rx_byte[7:4] == 4'h0 |=>
		$stable(setup_ff) && $stable(conv_ff) && $stable(avg_ff) && $stable(uni_ff) &&
		$stable(bi_ff))
		else $error("null byte changed state");
	a_no_pair_after: assert property (ce && wr_setup && !rx_byte[1] |=> !pair_pend_ff)
		else $error("pair write armed without addressing");
	a_start_write: assert property (ce && wr_conv && ck_mode[1] && st_ff == adc_cmd_pkg::ST_IDLE
		|=> st_ff != adc_cmd_pkg::ST_IDLE)
		else $error("conversion write did not start scan");
	a_ext_no_avg: assert property (ck_mode == 2'h3 && ce && st_ff == adc_cmd_pkg::ST_IDLE &&
		start_req |=> n_avg_ff == 6'h01 && reps_ff == 5'h1 && cur_ch_ff == last_ch_ff)
		else $error("external clock mode averaged or scanned");
	a_skip_strobe: assert property (sample_strobe && !sample_temp |->
		!ch_skip(sample_chan, setup_ff, uni_ff, bi_ff))
		else $error("reassigned channel was sampled");
	a_fifo_clear: assert property (ce && fifo_clr |=> !fifo_out_valid && dout == 1'b0)
		else $error("fifo not cleared");
	a_temp_first: assert property (ce && st_ff == adc_cmd_pkg::ST_IDLE && start_req &&
		csrc[0] && ref_mode != 2'h0 |=> st_ff == adc_cmd_pkg::ST_TEMP)
		else $error("temperature not first");
	a_sample_time: assert property (ce && st_ff == adc_cmd_pkg::ST_PUSH && fifo_in_ready
		|=> timer_ff == 16'(adc_cmd_pkg::T_CNV_CYC - 1))
		else $error("sample timer overrun");
	a_pair_seq: assert property (s_setup_pair |=> pair_pend_ff)
		else $error("pair addressing not armed");
endmodule : adc_serial_command_decoder

`default_nettype wire

// *** adc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module adc_host_model (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b1;
	end

	// one select-low frame, sclk idles low and stands still outside frames
	task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		#37 cs_n = 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			din = tx[i];
			#80 sclk = 1'b1;
			rx = {rx[14:0], dout};
			#80 sclk = 1'b0;
		end
		// setup plus pair byte is always sent as one 16-clock frame
		#80 cs_n = 1'b1;
		din = ~din;
	endtask : frame
endmodule : adc_host_model

`default_nettype wire

// *** test_adc_serial_command_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none

module test_adc_serial_command_decoder;
	logic sys_clk, sys_rst, ce, sclk, cs_n, din, start_n, dout;
	logic sample_strobe, sample_temp, sample_diff, ref_power, busy, first_temp, first_diff;
	logic [11:0] sample_data;
	logic [3:0] sample_chan;
	int n_mismatch = 0;
	int comparisons = 0;
	int n_strobe = 0;

	adc_serial_command_decoder #(.T_RP_CYC(4)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.ce(ce), .sclk(sclk), .cs_n(cs_n), .din(din), .conversion_start_pin_n(start_n),
		.sample_data(sample_data), .dout(dout), .sample_strobe(sample_strobe),
		.sample_chan(sample_chan), .sample_temp(sample_temp), .sample_diff(sample_diff),
		.ref_power(ref_power), .busy(busy));
	adc_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// front end answers with a per-channel code
	always @(posedge sys_clk) begin
		sample_data <= {8'hA5, sample_chan};
		if (sample_strobe === 1'b1) begin
			if (n_strobe == 0) begin
				first_temp <= sample_temp;
				first_diff <= sample_diff;
			end
			n_strobe <= n_strobe + 1;
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic conclude;
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude

	task automatic send(input logic [15:0] b, input int nbits);
		logic [15:0] rx;
		host.frame(b, nbits, rx);
		repeat (4) @(posedge sys_clk);
	endtask : send

	task automatic wait_idle;
		int i;
		i = 0;
		while (busy !== 1'b0 && i < 20000) begin
			@(posedge sys_clk);
			i++;
		end
		if (i >= 20000) begin
			check({15'h0000, busy}, 16'h0000);
			conclude();
		end
	endtask : wait_idle

	// reads n words and expects channel codes c0, c0+1, ...
	task automatic read_chans(input int n, input int c0, input logic [7:0] hi);
		logic [15:0] w;
		for (int i = 0; i < n; i++) begin
			host.frame(16'h0000, 16, w);
			check(w, {4'h0, hi, 4'(c0 + i)});
		end
	endtask : read_chans

	task automatic scan(input logic [15:0] b, input int nbits, input int n);
		n_strobe = 0;
		send(b, nbits);
		wait_idle();
		check(16'(n_strobe), 16'(n));
	endtask : scan

	task automatic t_reset;
		check({13'h0000, busy, ref_power, dout}, 16'h0000);
		read_chans(1, 0, 8'h00);
	endtask : t_reset

	task automatic t_modes;
		logic [15:0] w;
		scan(16'h00AE, 8, 1);
		read_chans(1, 5, 8'hA5);
		scan(16'h0091, 8, 4);
		check({15'h0000, first_temp}, 16'h0001);
		host.frame(16'h0000, 16, w);
		check({w[15:12], 12'h000}, 16'h0000);
		read_chans(3, 0, 8'hA5);
		scan(16'h00EA, 8, 3);
		read_chans(3, 13, 8'hA5);
		send(16'h0021, 8);
		scan(16'h009C, 8, 8);
		for (int i = 0; i < 8; i++) read_chans(1, 3, 8'hA5);
	endtask : t_modes

	task automatic t_fill;
		int i;
		i = 0;
		n_strobe = 0;
		send(16'h00C8, 8);
		while (n_strobe < 9 && i < 8000) begin
			@(posedge sys_clk);
			i++;
		end
		repeat (800) @(posedge sys_clk);
		check({15'h0000, busy}, 16'h0001);
		check(16'(n_strobe), 16'd9);
		read_chans(4, 0, 8'hA5);
		wait_idle();
		read_chans(6, 4, 8'hA5);
	endtask : t_fill

	task automatic t_avg;
		send(16'h0034, 8);
		send(16'h0005, 8);
		scan(16'h00AE, 8, 8);
		read_chans(1, 5, 8'hA5);
		send(16'h0070, 8);
		send(16'h0030, 8);
		scan(16'h00C8, 8, 1);
		read_chans(1, 9, 8'hA5);
		send(16'h0034, 8);
		send(16'h0010, 8);
		scan(16'h00AE, 8, 1);
		read_chans(1, 5, 8'hA5);
		scan(16'h00AE, 8, 1);
		send(16'h0018, 8);
		read_chans(1, 0, 8'h00);
	endtask : t_avg

	task automatic t_pairs;
		send(16'h6380, 16);
		scan(16'h0086, 8, 1);
		check({15'h0000, first_diff}, 16'h0001);
		read_chans(1, 0, 8'h25);
		send(16'h6280, 16);
		scan(16'h0086, 8, 1);
		read_chans(1, 0, 8'hA5);
		scan(16'h6186, 16, 1);
		read_chans(1, 0, 8'hA5);
	endtask : t_pairs

	task automatic t_pin;
		send(16'h0040, 8);
		n_strobe = 0;
		send(16'h00F2, 8);
		repeat (400) @(posedge sys_clk);
		check(16'(n_strobe), 16'd0);
		start_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		start_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wait_idle();
		check(16'(n_strobe), 16'd1);
		read_chans(1, 14, 8'hA5);
	endtask : t_pin

	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		start_n = 1'b1;
		sample_data = 12'h000;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_modes();
		t_fill();
		t_avg();
		t_pairs();
		t_pin();
		conclude();
	end
endmodule : test_adc_serial_command_decoder

`default_nettype wire
